// >>> src/scrlc_cfg.svh
/*
 * Offsets, field positions, reset values and timing for the soft reset and
 * live reconfiguration control. Assumes inclusion by bare name from src/.
 */
`ifndef SCRLC_CFG_SVH
`define SCRLC_CFG_SVH

// register offsets (7-bit address field)
`define SCRLC_ADDR_RESET_CONTROL 7'h09
`define SCRLC_ADDR_MODE_CONTROL 7'h0B
`define SCRLC_ADDR_FILTER_CONFIG 7'h0C
`define SCRLC_ADDR_STATUS 7'h0D
`define SCRLC_ADDR_DATA_HIGH 7'h0E
`define SCRLC_ADDR_DATA_LOW 7'h0F
`define SCRLC_ADDR_AMP_GAIN 7'h13
`define SCRLC_ADDR_POWER_DOWN_TWO 7'h15
`define SCRLC_ADDR_VOLT_CHAN_SEL 7'h17
`define SCRLC_ADDR_CURRENT_SOURCE 7'h18

// field positions
`define SCRLC_BIT_FULL_RESET 7
`define SCRLC_BIT_PATH_RESET 6
`define SCRLC_BIT_STOP 0
`define SCRLC_BIT_ST_NEW 0
`define SCRLC_BIT_ST_VALID 1
`define SCRLC_BIT_ST_INIT 2
`define SCRLC_BIT_ST_RUN 3

// reset values
`define SCRLC_RST_RESET_CONTROL 8'hC0
`define SCRLC_RST_MODE_CONTROL 8'h01
`define SCRLC_RST_MEAS_REG 8'h00

// serial frame: rw, 7 address bits, 8 data bits
`define SCRLC_FRAME_BITS 16
`define SCRLC_HDR_BITS 8

// timing
`define SCRLC_CLK_KHZ 40000
`define SCRLC_INIT_US 500
`define SCRLC_INIT_CYCLES (`SCRLC_INIT_US * `SCRLC_CLK_KHZ / 1000)
`define SCRLC_LP_OSC_KHZ 262
`define SCRLC_LP_TOGGLE_CYCLES (`SCRLC_CLK_KHZ / (2 * `SCRLC_LP_OSC_KHZ))
`define SCRLC_SCLK_HALF_CYCLES 8

`endif

// >>> src/scrlc_pkg.sv
/*
 * Types shared by both ends of the soft reset and live reconfiguration link.
 * Assumes scrlc_cfg.svh supplies the numbers.
 */
package scrlc_pkg;
  typedef enum logic [1:0] {
    SCRLC_INIT,
    SCRLC_STOPPED,
    SCRLC_RUNNING
  } scrlc_dev_state_type;

  typedef enum logic [2:0] {
    SCRLC_H_WAIT_INIT,
    SCRLC_H_IDLE,
    SCRLC_H_PRE_STOP,
    SCRLC_H_MAIN,
    SCRLC_H_RESTART
  } scrlc_host_state_type;
endpackage : scrlc_pkg

// >>> src/scrlc_if.sv
/*
 * Serial register link plus interrupt line between host and device.
 * Assumes the host makes the serial clock; all signals are single-driver.
 */
`timescale 1ns/100ps
`default_nettype none
interface scrlc_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic irq;
  modport device (input sclk, input cs_n, input mosi, output miso, output irq);
  modport host (output sclk, output cs_n, output mosi, input miso, input irq);
endinterface : scrlc_if
`default_nettype wire

// >>> src/scrlc_device.sv
/*
 * Device end: serial register slave, soft reset, measurement path reset,
 * initialization with toggling interrupt, live-writable register gating.
 * Assumes a host on scrlc_if and sample strobes from the converter on clk_in.
 */
// Function
// - zero in reset bit 7 resets whole device
// - full reset enters init, bit 6 reads one
// - init lasts 500 us, interrupt toggles
// - host ignores interrupt toggling during init
// - host configures only after init ends
// - reset bit 6 resets measurement path only
// - path reset restores only measurement registers
// - host path-resets only while stopped
// - external clock disabled during path reset
// - gain changes accepted while converting
// - first sample after gain change invalid
// - host skips first interrupt after gain change made while running
// - channel select and gain writable live
// - bypass and current source writable live
// - other registers need stop, configure, restart; mode and reset control are written without a stop
`timescale 1ns/100ps
`include "scrlc_cfg.svh"
`default_nettype none
module scrlc_device
  import scrlc_pkg::*;
#(
  parameter int INIT_CYCLES = `SCRLC_INIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // link
  scrlc_if.device link,
  // converter side
  input wire logic sample_strobe_in,
  input wire logic [15:0] sample_data_in,
  // measurement path settings and device state flags
  output logic [7:0] amp_gain_out,
  output logic [7:0] power_down_two_out,
  output logic [7:0] volt_chan_sel_out,
  output logic [7:0] current_source_out,
  output logic [7:0] filter_config_out,
  output logic running_out,
  output logic init_active_out
);

  function automatic logic is_live(input logic [6:0] a);
    is_live = (a == `SCRLC_ADDR_AMP_GAIN) || (a == `SCRLC_ADDR_POWER_DOWN_TWO) ||
              (a == `SCRLC_ADDR_VOLT_CHAN_SEL) || (a == `SCRLC_ADDR_CURRENT_SOURCE);
  endfunction : is_live

  scrlc_dev_state_type state;
  logic [2:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] mosi_sync;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [7:0] shift_out;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] reset_control;
  logic [7:0] mode_control;
  logic [15:0] sample_data;
  logic st_new;
  logic st_valid;
  logic gain_pending;
  logic [$clog2(INIT_CYCLES + 1)-1:0] init_cnt;
  logic [7:0] lp_cnt;
  logic irq_q;
  logic full_reset;
  logic path_reset;
  logic wr_ok;
  logic [7:0] rd_value;

  wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  wire cs_act = ~cs_sync[1];

  // link input synchronisers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sclk_sync <= 3'h0;
      cs_sync <= 2'h3;
      mosi_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      cs_sync <= {cs_sync[0], link.cs_n};
      mosi_sync <= {mosi_sync[0], link.mosi};
    end
  end

  // serial frame receive
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (!cs_act) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        shift_in <= {shift_in[14:0], mosi_sync[1]};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'(`SCRLC_HDR_BITS - 1)) begin
          rd_stb <= shift_in[6];
        end
        if (bit_cnt == 5'(`SCRLC_FRAME_BITS - 1) && !shift_in[14]) begin
          wr_stb <= 1'b1;
          wr_addr <= shift_in[13:7];
          wr_data <= {shift_in[6:0], mosi_sync[1]};
        end
      end
    end
  end

  always_comb begin
    case (shift_in[6:0])
      `SCRLC_ADDR_RESET_CONTROL: rd_value = reset_control;
      `SCRLC_ADDR_MODE_CONTROL: rd_value = mode_control;
      `SCRLC_ADDR_FILTER_CONFIG: rd_value = filter_config_out;
      `SCRLC_ADDR_STATUS: rd_value = {4'h0, running_out, init_active_out, st_valid, st_new};
      `SCRLC_ADDR_DATA_HIGH: rd_value = sample_data[15:8];
      `SCRLC_ADDR_DATA_LOW: rd_value = sample_data[7:0];
      `SCRLC_ADDR_AMP_GAIN: rd_value = amp_gain_out;
      `SCRLC_ADDR_POWER_DOWN_TWO: rd_value = power_down_two_out;
      `SCRLC_ADDR_VOLT_CHAN_SEL: rd_value = volt_chan_sel_out;
      `SCRLC_ADDR_CURRENT_SOURCE: rd_value = current_source_out;
      default: rd_value = 8'h00;
    endcase
  end

  // read data out, changed on falling serial clock
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      shift_out <= 8'h00;
      link.miso <= 1'b0;
    end else if (rd_stb) begin
      shift_out <= rd_value;
    end else if (cs_act && sclk_fall && bit_cnt >= 5'(`SCRLC_HDR_BITS)) begin
      link.miso <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // write decode; no writes during init, non-live ones other than mode and reset control only when stopped
  assign wr_ok = wr_stb && state != SCRLC_INIT &&
                 (state == SCRLC_STOPPED || is_live(wr_addr) ||
                  wr_addr == `SCRLC_ADDR_MODE_CONTROL ||
                  wr_addr == `SCRLC_ADDR_RESET_CONTROL);
  assign full_reset = wr_ok && wr_addr == `SCRLC_ADDR_RESET_CONTROL &&
                      !wr_data[`SCRLC_BIT_FULL_RESET];
  assign path_reset = wr_ok && wr_addr == `SCRLC_ADDR_RESET_CONTROL &&
                      wr_data[`SCRLC_BIT_FULL_RESET] && !wr_data[`SCRLC_BIT_PATH_RESET] &&
                      state == SCRLC_STOPPED;

  // reset control and mode control: untouched by a path reset
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || full_reset) begin
      reset_control <= `SCRLC_RST_RESET_CONTROL;
      mode_control <= `SCRLC_RST_MODE_CONTROL;
    end else if (wr_ok && wr_addr == `SCRLC_ADDR_MODE_CONTROL) begin
      mode_control <= wr_data;
    end
  end

  // measurement path registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || full_reset || path_reset) begin
      amp_gain_out <= `SCRLC_RST_MEAS_REG;
      power_down_two_out <= `SCRLC_RST_MEAS_REG;
      volt_chan_sel_out <= `SCRLC_RST_MEAS_REG;
      current_source_out <= `SCRLC_RST_MEAS_REG;
      filter_config_out <= `SCRLC_RST_MEAS_REG;
    end else if (wr_ok) begin
      case (wr_addr)
        `SCRLC_ADDR_AMP_GAIN: amp_gain_out <= wr_data;
        `SCRLC_ADDR_VOLT_CHAN_SEL: volt_chan_sel_out <= wr_data;
        `SCRLC_ADDR_POWER_DOWN_TWO: power_down_two_out <= wr_data;
        `SCRLC_ADDR_CURRENT_SOURCE: current_source_out <= wr_data;
        `SCRLC_ADDR_FILTER_CONFIG: filter_config_out <= wr_data;
        default: ;
      endcase
    end
  end

  // device state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || full_reset) begin
      state <= SCRLC_INIT;
      init_cnt <= '0;
    end else begin
      case (state)
        SCRLC_INIT: begin
          init_cnt <= init_cnt + ($clog2(INIT_CYCLES + 1))'(1);
          if (init_cnt == ($clog2(INIT_CYCLES + 1))'(INIT_CYCLES - 1)) begin
            state <= SCRLC_STOPPED;
          end
        end
        SCRLC_STOPPED: begin
          if (!mode_control[`SCRLC_BIT_STOP]) begin
            state <= SCRLC_RUNNING;
          end
        end
        SCRLC_RUNNING: begin
          if (mode_control[`SCRLC_BIT_STOP]) begin
            state <= SCRLC_STOPPED;
          end
        end
        default: state <= SCRLC_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      running_out <= 1'b0;
      init_active_out <= 1'b1;
    end else begin
      running_out <= state == SCRLC_RUNNING;
      init_active_out <= state == SCRLC_INIT;
    end
  end

  // sample capture; first sample after a gain write is flagged invalid
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || full_reset) begin
      sample_data <= 16'h0000;
      st_new <= 1'b0;
      st_valid <= 1'b0;
      gain_pending <= 1'b0;
    end else begin
      if (state == SCRLC_RUNNING && sample_strobe_in) begin
        sample_data <= sample_data_in;
        st_new <= 1'b1;
        st_valid <= !gain_pending;
        gain_pending <= 1'b0;
      end else if (rd_stb && shift_in[6:0] == `SCRLC_ADDR_STATUS) begin
        st_new <= 1'b0;
      end
      if (wr_ok && wr_addr == `SCRLC_ADDR_AMP_GAIN) begin
        gain_pending <= 1'b1;
      end
    end
  end

  // interrupt: low-power-rate toggle in init, else new-data flag
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || full_reset) begin
      lp_cnt <= 8'h00;
      irq_q <= 1'b0;
    end else if (state == SCRLC_INIT) begin
      if (lp_cnt == 8'(`SCRLC_LP_TOGGLE_CYCLES - 1)) begin
        lp_cnt <= 8'h00;
        irq_q <= ~irq_q;
      end else begin
        lp_cnt <= lp_cnt + 8'h01;
      end
    end else begin
      lp_cnt <= 8'h00;
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      link.irq <= 1'b0;
    end else begin
      link.irq <= (state == SCRLC_INIT) ? irq_q : st_new;
    end
  end

endmodule : scrlc_device
`default_nettype wire

// >>> src/scrlc_host.sv
/*
 * Host end: serial master with init hold-off, interrupt filtering,
 * gain-change sample skip, stop/restart wrapping and path-reset guarding.
 * Assumes a device on scrlc_if and one request at a time from the user.
 */
`timescale 1ns/100ps
`include "scrlc_cfg.svh"
`default_nettype none
module scrlc_host
  import scrlc_pkg::*;
#(
  parameter int INIT_CYCLES = `SCRLC_INIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // link
  scrlc_if.host link,
  // user request
  input wire logic req_in,
  input wire logic req_read_in,
  input wire logic [6:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  // user answer
  output logic busy_out,
  output logic done_out,
  output logic refused_out,
  output logic [7:0] read_data_out,
  output logic data_ready_out,
  output logic ext_clk_en_out
);

  // registers the device lets through while converting
  function automatic logic is_live(input logic [6:0] a);
    is_live = (a == `SCRLC_ADDR_AMP_GAIN) || (a == `SCRLC_ADDR_POWER_DOWN_TWO) ||
              (a == `SCRLC_ADDR_VOLT_CHAN_SEL) || (a == `SCRLC_ADDR_CURRENT_SOURCE);
  endfunction : is_live

  // writes that a running device would drop unless stopped first
  function automatic logic needs_wrap(input logic rd, input logic [6:0] a);
    needs_wrap = !rd && !is_live(a) && a != `SCRLC_ADDR_MODE_CONTROL &&
                 a != `SCRLC_ADDR_RESET_CONTROL;
  endfunction : needs_wrap

  scrlc_host_state_type state;
  logic [$clog2(INIT_CYCLES + 1)-1:0] wait_cnt;
  logic [1:0] irq_sync;
  logic irq_prev;
  logic skip_next;
  logic running;
  logic [6:0] addr_q;
  logic [7:0] data_q;
  logic rd_q;
  logic go;
  logic [15:0] frame;
  logic [4:0] bits;
  logic [3:0] div;
  logic active;
  logic xfer_done;
  logic [15:0] next_frame;

  // serial master: shift on falling, sample miso just before rising
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
      frame <= 16'h0000;
      bits <= 5'h00;
      div <= 4'h0;
      active <= 1'b0;
      xfer_done <= 1'b0;
      read_data_out <= 8'h00;
    end else begin
      xfer_done <= 1'b0;
      if (go && !active) begin
        active <= 1'b1;
        link.cs_n <= 1'b0;
        link.mosi <= next_frame[15];
        frame <= next_frame;
        bits <= 5'h00;
        div <= 4'h0;
      end else if (active) begin
        div <= div + 4'h1;
        if (div == 4'(`SCRLC_SCLK_HALF_CYCLES - 1)) begin
          div <= 4'h0;
          if (bits == 5'(`SCRLC_FRAME_BITS)) begin
            active <= 1'b0;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            xfer_done <= 1'b1;
          end else if (!link.sclk) begin
            link.sclk <= 1'b1;
            read_data_out <= {read_data_out[6:0], link.miso};
            frame <= {frame[14:0], 1'b0};
            bits <= bits + 5'h01;
          end else begin
            link.sclk <= 1'b0;
            link.mosi <= frame[15];
          end
        end
      end
    end
  end

  // sequencing of requests
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= SCRLC_H_WAIT_INIT;
      wait_cnt <= '0;
      go <= 1'b0;
      busy_out <= 1'b1;
      done_out <= 1'b0;
      refused_out <= 1'b0;
      running <= 1'b0;
      addr_q <= 7'h00;
      data_q <= 8'h00;
      rd_q <= 1'b0;
      ext_clk_en_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      refused_out <= 1'b0;
      go <= 1'b0;
      case (state)
        SCRLC_H_WAIT_INIT: begin
          wait_cnt <= wait_cnt + ($clog2(INIT_CYCLES + 1))'(1);
          if (wait_cnt == ($clog2(INIT_CYCLES + 1))'(INIT_CYCLES)) begin
            state <= SCRLC_H_IDLE;
            busy_out <= 1'b0;
          end
        end
        SCRLC_H_IDLE: begin
          if (req_in) begin
            if (!req_read_in && req_addr_in == `SCRLC_ADDR_RESET_CONTROL &&
                req_data_in[`SCRLC_BIT_FULL_RESET] &&
                !req_data_in[`SCRLC_BIT_PATH_RESET] && running) begin
              refused_out <= 1'b1;
            end else begin
              busy_out <= 1'b1;
              rd_q <= req_read_in;
              addr_q <= req_addr_in;
              data_q <= req_data_in;
              if (!req_read_in && req_addr_in == `SCRLC_ADDR_RESET_CONTROL &&
                  !req_data_in[`SCRLC_BIT_PATH_RESET]) begin
                ext_clk_en_out <= 1'b0;
              end
              if (running && needs_wrap(req_read_in, req_addr_in)) begin
                state <= SCRLC_H_PRE_STOP;
              end else begin
                state <= SCRLC_H_MAIN;
              end
              go <= 1'b1;
            end
          end
        end
        default: begin
          if (xfer_done) begin
            go <= 1'b1;
            case (state)
              SCRLC_H_PRE_STOP: state <= SCRLC_H_MAIN;
              SCRLC_H_MAIN: begin
                if (running && needs_wrap(rd_q, addr_q)) begin
                  state <= SCRLC_H_RESTART;
                end else begin
                  go <= 1'b0;
                  state <= SCRLC_H_IDLE;
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
                  ext_clk_en_out <= 1'b1;
                  if (!rd_q && addr_q == `SCRLC_ADDR_MODE_CONTROL) begin
                    running <= !data_q[`SCRLC_BIT_STOP];
                  end
                  if (!rd_q && addr_q == `SCRLC_ADDR_RESET_CONTROL &&
                      !data_q[`SCRLC_BIT_FULL_RESET]) begin
                    running <= 1'b0;
                    busy_out <= 1'b1;
                    wait_cnt <= '0;
                    state <= SCRLC_H_WAIT_INIT;
                  end
                end
              end
              default: begin
                go <= 1'b0;
                state <= SCRLC_H_IDLE;
                busy_out <= 1'b0;
                done_out <= 1'b1;
              end
            endcase
          end
        end
      endcase
      if (state == SCRLC_H_IDLE) begin
        wait_cnt <= '0;
      end
    end
  end

  // frame contents per step: stop, request, restart
  always_comb begin
    case (state)
      SCRLC_H_PRE_STOP: next_frame = {1'b0, `SCRLC_ADDR_MODE_CONTROL, 8'(1 << `SCRLC_BIT_STOP)};
      SCRLC_H_RESTART: next_frame = {1'b0, `SCRLC_ADDR_MODE_CONTROL, 8'h00};
      default: next_frame = {rd_q, addr_q, data_q};
    endcase
  end

  // interrupt: ignored during init, first one after a gain write made while running skipped
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_sync <= 2'h0;
      irq_prev <= 1'b0;
      skip_next <= 1'b0;
      data_ready_out <= 1'b0;
    end else begin
      irq_sync <= {irq_sync[0], link.irq};
      irq_prev <= irq_sync[1];
      data_ready_out <= 1'b0;
      if (state != SCRLC_H_WAIT_INIT && irq_sync[1] && !irq_prev) begin
        if (skip_next) begin
          skip_next <= 1'b0;
        end else begin
          data_ready_out <= 1'b1;
        end
      end
      if (xfer_done && state == SCRLC_H_MAIN && !rd_q && addr_q == `SCRLC_ADDR_AMP_GAIN) begin
        skip_next <= running;
      end
    end
  end

endmodule : scrlc_host
`default_nettype wire

// >>> dv/scrlc_asserts.sv
/* Wire checks on the serial register link and interrupt line.
   Assumes clk_in and reset_n_in are shared by both ends. */
`timescale 1ns/100ps
`default_nettype none
module scrlc_asserts #(
  parameter int INIT_CYCLES = 200
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic irq
);
  logic [15:0] cyc;
  logic [4:0] rises;

  // cycles since reset release, saturating
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) cyc <= 16'h0000;
    else if (cyc != 16'hFFFF) cyc <= cyc + 16'h0001;
  end

  // serial clock rises within the current frame
  always_ff @(posedge clk_in) begin
    if (cs_n) rises <= 5'h00;
    else if ($rose(sclk)) rises <= rises + 5'h01;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_no_frame_in_init;
    cyc < INIT_CYCLES |-> cs_n;
  endproperty
  property p_init_toggle;
    $changed(irq) && cyc < INIT_CYCLES - 100 |-> ##[70:80] $changed(irq);
  endproperty
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  property p_sclk_high;
    $rose(sclk) |-> sclk[*8] ##1 !sclk;
  endproperty
  property p_sclk_low;
    $fell(sclk) |-> !sclk[*8];
  endproperty
  property p_mosi_hold;
    !cs_n && sclk |-> $stable(mosi);
  endproperty
  property p_frame_bits;
    $rose(cs_n) |-> rises == 5'h10;
  endproperty
  property p_frame_len;
    $fell(cs_n) |-> ##[250:280] $rose(cs_n);
  endproperty

  a_no_frame_in_init: assert property (p_no_frame_in_init)
    else $error("frame started during initialization");
  a_init_toggle: assert property (p_init_toggle)
    else $error("interrupt stopped toggling during initialization");
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock not low outside a frame");
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high phase not 8 cycles");
  a_sclk_low: assert property (p_sclk_low)
    else $error("serial clock low phase shorter than 8 cycles");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data changed while serial clock high");
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame did not carry 16 bits");
  a_frame_len: assert property (p_frame_len)
    else $error("frame length out of range");

  c_frame: cover property ($rose(cs_n));
  c_read_frame: cover property ($fell(cs_n) ##1 mosi);
  c_irq_after_init: cover property (cyc > INIT_CYCLES && $rose(irq));
endmodule : scrlc_asserts
`default_nettype wire

// >>> dv/test_soft_reset_and_live_reconfig_ctl.sv
/* Self-checking bench: host and device joined by scrlc_if, user requests
   through the host, converter samples into the device.
   Assumes INIT_CYCLES shortened to 200 on both ends. */
`timescale 1ns/100ps
`default_nettype none
module test_soft_reset_and_live_reconfig_ctl;
  localparam int INIT = 200;
  localparam logic [6:0] ADDRS [5] = '{7'h0C, 7'h15, 7'h17, 7'h18, 7'h13};
  localparam logic [7:0] VALS [5] = '{8'h5A, 8'h22, 8'h33, 8'h44, 8'h11};
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic req_in = 1'b0;
  logic req_read_in = 1'b0;
  logic [6:0] req_addr_in = 7'h00;
  logic [7:0] req_data_in = 8'h00;
  logic sample_strobe_in = 1'b0;
  logic [15:0] sample_data_in = 16'hA5C3;
  logic busy_out, done_out, refused_out, data_ready_out, ext_clk_en_out;
  logic running_out, init_active_out;
  logic [7:0] read_data_out, gain, bypass, chan, isrc, filt, q;
  logic [7:0] outs [5];
  logic rf;
  logic clk_off = 1'b0;
  int ready_count = 0;
  int base;
  int fail_count = 0;
  int num_checks = 0;

  always #12.5 clk_in = ~clk_in;
  assign outs = '{filt, bypass, chan, isrc, gain};

  always @(posedge clk_in) begin
    if (ext_clk_en_out === 1'b0) clk_off <= 1'b1;
    if (data_ready_out === 1'b1) ready_count <= ready_count + 1;
  end

  scrlc_if scrlc_if_inst ();
  scrlc_device #(.INIT_CYCLES(INIT)) scrlc_device_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .link(scrlc_if_inst.device),
    .sample_strobe_in(sample_strobe_in), .sample_data_in(sample_data_in),
    .amp_gain_out(gain), .power_down_two_out(bypass), .volt_chan_sel_out(chan),
    .current_source_out(isrc), .filter_config_out(filt),
    .running_out(running_out), .init_active_out(init_active_out));
  scrlc_host #(.INIT_CYCLES(INIT)) scrlc_host_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .link(scrlc_if_inst.host),
    .req_in(req_in), .req_read_in(req_read_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .busy_out(busy_out), .done_out(done_out),
    .refused_out(refused_out), .read_data_out(read_data_out),
    .data_ready_out(data_ready_out), .ext_clk_en_out(ext_clk_en_out));
  scrlc_asserts #(.INIT_CYCLES(INIT)) scrlc_asserts_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sclk(scrlc_if_inst.sclk),
    .cs_n(scrlc_if_inst.cs_n), .mosi(scrlc_if_inst.mosi),
    .miso(scrlc_if_inst.miso), .irq(scrlc_if_inst.irq));

  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // waits for the host (0) or the device (1) to leave its busy phase
  task automatic wait_clear(input bit dev);
    int n = 0;
    while ((dev ? init_active_out : busy_out) !== 1'b0) begin
      @(posedge clk_in);
      n++;
      if (n > 5000) begin
        fail_count++;
        report_and_stop();
      end
    end
  endtask : wait_clear

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n = 0;
    wait_clear(1'b0);
    req_in <= 1'b1;
    req_read_in <= rd;
    req_addr_in <= a;
    req_data_in <= d;
    @(posedge clk_in);
    req_in <= 1'b0;
    rf = 1'b0;
    while (done_out !== 1'b1 && !rf) begin
      @(posedge clk_in);
      rf = (refused_out === 1'b1);
      n++;
      if (n > 3000) begin
        fail_count++;
        report_and_stop();
      end
    end
    q = read_data_out;
  endtask : xfer

  task automatic pulse_sample();
    sample_strobe_in <= 1'b1;
    @(posedge clk_in);
    sample_strobe_in <= 1'b0;
    repeat (20) @(posedge clk_in);
  endtask : pulse_sample

  task automatic do_reset(input int n);
    reset_n_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
  endtask : do_reset

  initial begin
    do_reset(20);
    check({7'h00, busy_out}, 8'h01);
    check({7'h00, init_active_out}, 8'h01);
    wait_clear(1'b0);
    check({7'h00, init_active_out}, 8'h00);
    xfer(1'b1, 7'h09, 8'h00);
    check(q, 8'hC0);
    foreach (ADDRS[i]) xfer(1'b0, ADDRS[i], VALS[i]);
    foreach (outs[i]) check(outs[i], VALS[i]);
    // measurement path reset while stopped
    xfer(1'b0, 7'h09, 8'h80);
    check({7'h00, clk_off}, 8'h01);
    check({7'h00, ext_clk_en_out}, 8'h01);
    foreach (outs[i]) check(outs[i], 8'h00);
    xfer(1'b1, 7'h0B, 8'h00);
    check(q, 8'h01);
    // run, then reconfigure
    xfer(1'b0, 7'h0B, 8'h00);
    check({7'h00, running_out}, 8'h01);
    xfer(1'b0, 7'h0C, 8'h66);
    check(filt, 8'h66);
    check({7'h00, running_out}, 8'h01);
    foreach (ADDRS[i]) begin
      if (i > 0) begin
        xfer(1'b0, ADDRS[i], ~VALS[i]);
        check(outs[i], ~VALS[i]);
        check({7'h00, running_out}, 8'h01);
      end
    end
    base = ready_count;
    pulse_sample();
    xfer(1'b1, 7'h0D, 8'h00);
    check(q, 8'h09);
    pulse_sample();
    xfer(1'b1, 7'h0D, 8'h00);
    check(q, 8'h0B);
    xfer(1'b1, 7'h0E, 8'h00);
    check(q, 8'hA5);
    check(8'(ready_count - base), 8'h01);
    xfer(1'b0, 7'h09, 8'h80);
    check({7'h00, rf}, 8'h01);
    check(gain, 8'hEE);
    // whole-device soft reset
    xfer(1'b0, 7'h09, 8'h40);
    check({7'h00, init_active_out}, 8'h01);
    check(gain, 8'h00);
    wait_clear(1'b1);
    xfer(1'b1, 7'h09, 8'h00);
    check(q, 8'hC0);
    // second reset while stopped
    do_reset(4);
    base = ready_count;
    wait_clear(1'b0);
    check(8'(ready_count - base), 8'h00);
    report_and_stop();
  end
endmodule : test_soft_reset_and_live_reconfig_ctl
`default_nettype wire
